// file: scad_map.svh
// Address map, field positions and reset values for the stream controller address map
`ifndef SCAD_MAP_SVH
`define SCAD_MAP_SVH
`define SCAD_ENG0_BASE 12'h000
`define SCAD_ENG1_BASE 12'h400
`define SCAD_ENG_SIZE 12'h400
`define SCAD_PAGE_OFS 12'h800
`define SCAD_BUILD_OFS 12'h804
`define SCAD_PAGE_RESET 32'h0000_0000
`define SCAD_PAGE_LSB 0
`define SCAD_PAGE_MSB 14
`define SCAD_HOST_AW 17
`define SCAD_EXT_AW 32
`define SCAD_BI_REV_LSB 0
`define SCAD_BI_CHAN_LSB 8
`define SCAD_BI_DW_LSB 16
`define SCAD_BI_LEN_LSB 24
`define SCAD_BI_SG_BIT 31
`define SCAD_RESP_OKAY 2'h0
`define SCAD_RESP_SLVERR 2'h2
`endif

// file: scad_pkg.sv
// Types shared by the stream controller address map
`default_nettype none
package scad_pkg;
  typedef enum logic [1:0] {
    SCAD_TGT_ENG0 = 2'h0,
    SCAD_TGT_ENG1 = 2'h1,
    SCAD_TGT_LOCAL = 2'h3
  } scad_tgt_t;

  // AXI4-Lite request toward one engine register window
  typedef struct packed {
    logic [11:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [11:0] araddr;
    logic arvalid;
    logic rready;
  } scad_lite_req_t;

  // AXI4-Lite answer from one engine register window
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } scad_lite_rsp_t;
endpackage
`default_nettype wire

// file: scad_page_xlat.sv
// Page translation from the host memory port address to the external address
`include "scad_map.svh"
`timescale 1ns/1ps
`default_nettype none
module scad_page_xlat #(
  parameter int HOST_AW = `SCAD_HOST_AW,
  parameter int EXT_AW = `SCAD_EXT_AW
) (
  // Page value
  input wire logic [EXT_AW-HOST_AW-1:0] page,
  // Addresses
  input wire logic [HOST_AW-1:0] host_addr,
  output logic [EXT_AW-1:0] ext_addr
);
  // Low bits pass straight through; a page is one 2^HOST_AW byte window
  assign ext_addr = {page, host_addr};
endmodule
`default_nettype wire

// file: scad_ctrl_map.sv
// Control-port decode, page register, build info and host address widening
`include "scad_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Control byte offsets 0 to 1023 go to the first transfer engine's registers.
// - Control byte offsets 1024 to 2047 go to the second transfer engine's registers.
// - A write-only page register sits at byte offset 2048 and reads back as zero.
// - A read-only build info register sits at byte offset 2052 and ignores writes.
// - External address bits 31:17 come from page register bits 14:0.
// - The 17-bit host address passes unchanged as the low external address bits.
// - Build info bits 7:0 give the revision and bits 15:8 the channel count.
// - Build info bits 23:16 give stream data width and bits 30:24 length register width.
// - Build info bit 31 is 0 for simple DMA and 1 for scatter/gather DMA.
// - Two independent engines run in direct register mode behind their windows.
// - The control port is an AXI4-Lite slave with 12-bit address and 32-bit data.
// - The external memory port is an AXI4 master with 32-bit address and 128-bit data.
// - The host memory port is an AXI4 slave with 17 address bits and 32 data bits.
module scad_ctrl_map
  import scad_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'h01, // Arbitrary value
  parameter logic [7:0] NUM_CHANNELS = 8'h02,
  parameter logic [7:0] STREAM_WIDTH = 8'h20,
  parameter logic [6:0] LEN_WIDTH = 7'h17,
  parameter logic SCATTER_GATHER = 1'b0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control AXI4-Lite slave
  input wire logic [11:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [11:0] s_araddr,
  input wire logic [2:0] s_arprot,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Transfer engine register windows
  output scad_pkg::scad_lite_req_t eng0_req,
  input wire scad_pkg::scad_lite_rsp_t eng0_rsp,
  output scad_pkg::scad_lite_req_t eng1_req,
  input wire scad_pkg::scad_lite_rsp_t eng1_rsp,
  // Host memory port address widening
  input wire logic [`SCAD_HOST_AW-1:0] host_awaddr,
  input wire logic [`SCAD_HOST_AW-1:0] host_araddr,
  output logic [`SCAD_EXT_AW-1:0] ext_awaddr,
  output logic [`SCAD_EXT_AW-1:0] ext_araddr
);
  import scad_pkg::*;

  localparam int PW = `SCAD_EXT_AW - `SCAD_HOST_AW;

  // ==========================================================================
  // Target decode
  // ==========================================================================
  function automatic scad_tgt_t decode(input logic [11:0] a);
    scad_tgt_t t;
    if (a < `SCAD_ENG1_BASE) begin
      t = SCAD_TGT_ENG0;
    end else if (a < `SCAD_PAGE_OFS) begin
      t = SCAD_TGT_ENG1;
    end else begin
      t = SCAD_TGT_LOCAL;
    end
    return t;
  endfunction

  // Write channel: one transaction at a time, address and data taken together
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_FWD = 2'b01,
    WR_RESP = 2'b11
  } scad_wr_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_FWD = 2'b01,
    RD_RESP = 2'b11
  } scad_rd_t;

  scad_wr_t wr_q;
  scad_rd_t rd_q;
  scad_tgt_t wtgt_q;
  scad_tgt_t rtgt_q;
  logic [11:0] waddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_sent_q;
  logic w_sent_q;
  logic [11:0] raddr_q;
  logic ar_sent_q;
  logic [1:0] bresp_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [PW-1:0] page_q;
  logic [31:0] build_info;
  logic wr_take;
  logic rd_take;
  scad_lite_rsp_t wrsp;
  scad_lite_rsp_t rrsp;

  // Waiting for both halves keeps the slave simple at the cost of overlap
  assign wr_take = (wr_q == WR_IDLE) && s_awvalid && s_wvalid;
  assign rd_take = (rd_q == RD_IDLE) && s_arvalid;
  assign s_awready = wr_take;
  assign s_wready = wr_take;
  assign s_arready = rd_take;
  assign s_bvalid = (wr_q == WR_RESP);
  assign s_bresp = bresp_q;
  assign s_rvalid = (rd_q == RD_RESP);
  assign s_rdata = rdata_q;
  assign s_rresp = rresp_q;

  assign build_info = {SCATTER_GATHER, LEN_WIDTH, STREAM_WIDTH, NUM_CHANNELS,
                       REVISION};

  assign wrsp = (wtgt_q == SCAD_TGT_ENG1) ? eng1_rsp : eng0_rsp;
  assign rrsp = (rtgt_q == SCAD_TGT_ENG1) ? eng1_rsp : eng0_rsp;

  // ==========================================================================
  // Engine window requests
  // ==========================================================================
  // Window-relative offsets; each engine sees its own 1 kB space from zero
  always_comb begin
    eng0_req = '0;
    eng1_req = '0;
    if (wr_q == WR_FWD && wtgt_q == SCAD_TGT_ENG0) begin
      eng0_req.awaddr = waddr_q - `SCAD_ENG0_BASE;
      eng0_req.awvalid = !aw_sent_q;
      eng0_req.wdata = wdata_q;
      eng0_req.wstrb = wstrb_q;
      eng0_req.wvalid = !w_sent_q;
      eng0_req.bready = 1'b1;
    end else if (wr_q == WR_FWD && wtgt_q == SCAD_TGT_ENG1) begin
      eng1_req.awaddr = waddr_q - `SCAD_ENG1_BASE;
      eng1_req.awvalid = !aw_sent_q;
      eng1_req.wdata = wdata_q;
      eng1_req.wstrb = wstrb_q;
      eng1_req.wvalid = !w_sent_q;
      eng1_req.bready = 1'b1;
    end
    if (rd_q == RD_FWD && rtgt_q == SCAD_TGT_ENG0) begin
      eng0_req.araddr = raddr_q - `SCAD_ENG0_BASE;
      eng0_req.arvalid = !ar_sent_q;
      eng0_req.rready = 1'b1;
    end else if (rd_q == RD_FWD && rtgt_q == SCAD_TGT_ENG1) begin
      eng1_req.araddr = raddr_q - `SCAD_ENG1_BASE;
      eng1_req.arvalid = !ar_sent_q;
      eng1_req.rready = 1'b1;
    end
  end

  // ==========================================================================
  // Write path
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= WR_IDLE;
      wtgt_q <= SCAD_TGT_LOCAL;
      waddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      aw_sent_q <= 1'b0;
      w_sent_q <= 1'b0;
      bresp_q <= `SCAD_RESP_OKAY;
    end else begin
      case (wr_q)
        WR_IDLE: begin
          if (wr_take) begin
            waddr_q <= s_awaddr;
            wdata_q <= s_wdata;
            wstrb_q <= s_wstrb;
            wtgt_q <= decode(s_awaddr);
            aw_sent_q <= 1'b0;
            w_sent_q <= 1'b0;
            bresp_q <= `SCAD_RESP_OKAY;
            wr_q <= (decode(s_awaddr) == SCAD_TGT_LOCAL) ? WR_RESP : WR_FWD;
          end
        end
        WR_FWD: begin
          if (wrsp.awready) begin
            aw_sent_q <= 1'b1;
          end
          if (wrsp.wready) begin
            w_sent_q <= 1'b1;
          end
          if (wrsp.bvalid) begin
            bresp_q <= wrsp.bresp;
            wr_q <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_bready) begin
            wr_q <= WR_IDLE;
          end
        end
        default: begin
          wr_q <= WR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Page register
  // ==========================================================================
  // Only the low PW bits are kept; upper bits of the written word are dropped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_q <= PW'(`SCAD_PAGE_RESET);
    end else if (wr_take && s_awaddr[11:2] == 10'(`SCAD_PAGE_OFS >> 2)) begin
      if (s_wstrb[0]) begin
        page_q[7:0] <= s_wdata[7:0];
      end
      if (s_wstrb[1]) begin
        page_q[PW-1:8] <= s_wdata[`SCAD_PAGE_MSB:8];
      end
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_q <= RD_IDLE;
      rtgt_q <= SCAD_TGT_LOCAL;
      raddr_q <= 12'h000;
      ar_sent_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `SCAD_RESP_OKAY;
    end else begin
      case (rd_q)
        RD_IDLE: begin
          if (rd_take) begin
            raddr_q <= s_araddr;
            rtgt_q <= decode(s_araddr);
            ar_sent_q <= 1'b0;
            rresp_q <= `SCAD_RESP_OKAY;
            if (decode(s_araddr) != SCAD_TGT_LOCAL) begin
              rd_q <= RD_FWD;
            end else begin
              rd_q <= RD_RESP;
              if (s_araddr[11:2] == 10'(`SCAD_BUILD_OFS >> 2)) begin
                rdata_q <= build_info;
              end else begin
                rdata_q <= 32'h0000_0000;
              end
            end
          end
        end
        RD_FWD: begin
          if (rrsp.arready) begin
            ar_sent_q <= 1'b1;
          end
          if (rrsp.rvalid) begin
            rdata_q <= rrsp.rdata;
            rresp_q <= rrsp.rresp;
            rd_q <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (s_rready) begin
            rd_q <= RD_IDLE;
          end
        end
        default: begin
          rd_q <= RD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Host address widening
  // ==========================================================================
  // Host keeps the page current before leaving it; nothing here checks that
  scad_page_xlat #(
    .HOST_AW(`SCAD_HOST_AW),
    .EXT_AW(`SCAD_EXT_AW)
  ) u_xlat_aw (
    .page(page_q),
    .host_addr(host_awaddr),
    .ext_addr(ext_awaddr)
  );

  scad_page_xlat #(
    .HOST_AW(`SCAD_HOST_AW),
    .EXT_AW(`SCAD_EXT_AW)
  ) u_xlat_ar (
    .page(page_q),
    .host_addr(host_araddr),
    .ext_addr(ext_araddr)
  );
endmodule
`default_nettype wire

// file: scad_ctrl_map_properties.sv
// Port assertions for the stream controller address map
`timescale 1ns/1ps
`default_nettype none
module scad_ctrl_map_props
  import scad_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Control port
  input wire logic [11:0] s_awaddr,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  input wire logic [1:0] s_bresp,
  input wire logic s_bvalid,
  input wire logic [11:0] s_araddr,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic [31:0] s_rdata,
  input wire logic s_rvalid,
  // Engine windows
  input wire scad_pkg::scad_lite_req_t eng0_req,
  input wire scad_pkg::scad_lite_req_t eng1_req,
  // Host address widening
  input wire logic [16:0] host_awaddr,
  input wire logic [16:0] host_araddr,
  input wire logic [31:0] ext_awaddr,
  input wire logic [31:0] ext_araddr
);
  // ====================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd_take;
    s_arvalid && s_arready;
  endsequence
  sequence s_wr_take;
    s_awvalid && s_wvalid && s_awready;
  endsequence
  a_low_bits_pass: assert property (
    ext_awaddr[16:0] == host_awaddr && ext_araddr[16:0] == host_araddr)
    else $error("low address bits altered");
  a_page_both_ports: assert property (
    ext_awaddr[31:17] == ext_araddr[31:17])
    else $error("page bits differ between ports");
  a_page_full_write: assert property (
    s_wr_take ##0 s_awaddr[11:2] == 10'h200 && s_wstrb[1:0] == 2'b11
    |=> ext_awaddr[31:17] == $past(s_wdata[14:0]))
    else $error("page write not applied");
  a_page_holds: assert property (
    !(s_awvalid && s_wvalid && s_awready && s_awaddr[11:2] == 10'h200)
    |=> $stable(ext_awaddr[31:17]))
    else $error("page changed without a write");
  a_build_read: assert property (
    s_rd_take ##0 s_araddr[11:2] == 10'h201 |=> s_rvalid && s_rdata == 32'h1720_0201)
    else $error("build info value wrong");
  a_local_zero: assert property (
    s_rd_take ##0 s_araddr[11] && s_araddr[11:2] != 10'h201 |=> s_rvalid && s_rdata == 32'h0)
    else $error("local read not zero");
  a_eng0_route: assert property (
    s_rd_take ##0 s_araddr[11:10] == 2'b00 |=> eng0_req.arvalid && !eng1_req.arvalid
    && eng0_req.araddr == {2'b00, $past(s_araddr[9:0])})
    else $error("read not sent to engine zero");
  a_eng1_route: assert property (
    s_rd_take ##0 s_araddr[11:10] == 2'b01 |=> eng1_req.arvalid && !eng0_req.arvalid
    && eng1_req.araddr == {2'b00, $past(s_araddr[9:0])})
    else $error("read not sent to engine one");
  a_local_wr_okay: assert property (
    s_wr_take ##0 s_awaddr[11] |=> s_bvalid && s_bresp == 2'h0)
    else $error("local write answer wrong");
  // Forwarded writes carry the window-relative address and the taken data and strobes unchanged
  a_eng0_write: assert property (
    s_wr_take ##0 s_awaddr[11:10] == 2'b00 |=> eng0_req.awvalid && eng0_req.wvalid
    && !eng1_req.awvalid && eng0_req.awaddr == {2'b00, $past(s_awaddr[9:0])}
    && eng0_req.wdata == $past(s_wdata) && eng0_req.wstrb == $past(s_wstrb))
    else $error("write not sent to engine zero");
  a_eng1_write: assert property (
    s_wr_take ##0 s_awaddr[11:10] == 2'b01 |=> eng1_req.awvalid && eng1_req.wvalid
    && !eng0_req.awvalid && eng1_req.awaddr == {2'b00, $past(s_awaddr[9:0])}
    && eng1_req.wdata == $past(s_wdata) && eng1_req.wstrb == $past(s_wstrb))
    else $error("write not sent to engine one");
endmodule
bind scad_ctrl_map scad_ctrl_map_props scad_ctrl_map_props_i (.*);
`default_nettype wire

// file: scad_eng_model.sv
// Behavioural model of one transfer engine register window
`timescale 1ns/1ps
`default_nettype none
module scad_eng_model
  import scad_pkg::*;
#(
  parameter int WAIT = 0,
  parameter logic [7:0] TAG = 8'h00
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Register window
  input wire scad_pkg::scad_lite_req_t req,
  output scad_pkg::scad_lite_rsp_t rsp
);
  // ====================
  // Handshakes
  int cnt_q;
  logic rd_go, wr_go, rv_q, bv_q;
  logic [31:0] rd_q;
  logic [1:0] rr_q;
  logic [1:0] br_q;
  // A slow window keeps ready low for WAIT cycles to stall the forwarding path
  assign rd_go = req.arvalid && !rv_q && cnt_q >= WAIT;
  assign wr_go = req.awvalid && req.wvalid && !bv_q && cnt_q >= WAIT;
  assign rsp = {wr_go, wr_go, br_q, bv_q, rd_go, rd_q, rr_q, rv_q};
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
      rv_q <= 1'b0;
      bv_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= 2'h0;
      br_q <= 2'h0;
    end else begin
      cnt_q <= ((req.arvalid || req.awvalid) && !rd_go && !wr_go) ? cnt_q + 1 : 0;
      if (rd_go) begin
        rv_q <= 1'b1;
        rd_q <= {TAG, 12'h000, req.araddr};
        rr_q <= req.araddr[2] ? 2'h2 : 2'h0;
      end else if (rv_q && req.rready) begin
        // Released data is scrambled so stale values never look valid
        rv_q <= 1'b0;
        rd_q <= ~rd_q;
      end
      if (wr_go) begin
        bv_q <= 1'b1;
        // Error answer on odd words proves the response is passed through
        br_q <= req.awaddr[2] ? 2'h2 : 2'h0;
      end else if (bv_q && req.bready) begin
        bv_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking testbench for the stream controller address map
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scad_pkg::*;
  // ====================
  // Signals
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
  logic [2:0] s_awprot = 3'h0, s_arprot = 3'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd_v, ext_awaddr, ext_araddr;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_arvalid = 1'b0;
  logic s_bready = 1'b1, s_rready = 1'b1;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp, rs_v;
  logic [16:0] host_awaddr = 17'h1_2345, host_araddr = 17'h0_0ABC;
  scad_lite_req_t eng0_req, eng1_req;
  scad_lite_rsp_t eng0_rsp, eng1_rsp;
  int fail_count = 0, n_compared = 0, cycles = 0;
  always #5 sys_clk = ~sys_clk;
  scad_ctrl_map scad_ctrl_map_i (.*);
  scad_eng_model #(.WAIT(0), .TAG(8'hA0)) scad_eng_model_0_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .req(eng0_req), .rsp(eng0_rsp));
  scad_eng_model #(.WAIT(3), .TAG(8'hB1)) scad_eng_model_1_i (.sys_clk(sys_clk),
    .arst_n(arst_n), .req(eng1_req), .rsp(eng1_rsp));
  // ====================
  // Bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    s_awaddr = a;
    s_wdata = d;
    s_wstrb = s;
    s_awvalid = 1'b1;
    s_wvalid = 1'b1;
    #1;
    while (s_awready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    s_awvalid = 1'b0;
    s_wvalid = 1'b0;
    while (s_bvalid !== 1'b1) @(negedge sys_clk);
    rs_v = s_bresp;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a);
    s_araddr = a;
    s_arvalid = 1'b1;
    #1;
    while (s_arready !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    s_arvalid = 1'b0;
    while (s_rvalid !== 1'b1) @(negedge sys_clk);
    rd_v = s_rdata;
    rs_v = s_rresp;
    @(negedge sys_clk);
  endtask
  // ====================
  // Scenarios
  task automatic t_page();
    chk(ext_awaddr, {15'h0000, host_awaddr});
    wr(12'h800, 32'h0000_7ABC, 4'hF);
    chk({30'h0, rs_v}, 32'h0);
    chk(ext_awaddr, {15'h7ABC, host_awaddr});
    host_araddr = 17'h1_FFFF;
    @(negedge sys_clk);
    chk(ext_araddr, {15'h7ABC, 17'h1_FFFF});
    wr(12'h800, 32'h0000_0055, 4'h1);
    chk({17'h0, ext_awaddr[31:17]}, 32'h0000_7A55);
    wr(12'h800, 32'hFFFF_FFFF, 4'hF);
    chk({17'h0, ext_araddr[31:17]}, 32'h0000_7FFF);
    rd(12'h800);
    chk(rd_v, 32'h0);
  endtask
  task automatic t_build();
    rd(12'h804);
    chk(rd_v, 32'h1720_0201);
    wr(12'h804, 32'hFFFF_FFFF, 4'hF);
    rd(12'h804);
    chk(rd_v, 32'h1720_0201);
  endtask
  task automatic t_engines();
    logic [11:0] a[4] = '{12'h004, 12'h3F8, 12'h404, 12'h7F8};
    for (int i = 0; i < 4; i++) begin
      rd(a[i]);
      chk(rd_v, {a[i][10] ? 8'hB1 : 8'hA0, 14'h0000, a[i][9:0]});
      chk({30'h0, rs_v}, {30'h0, a[i][2], 1'b0});
      wr(a[i], 32'h0000_1234, 4'hF);
      chk({30'h0, rs_v}, {30'h0, a[i][2], 1'b0});
    end
  endtask
  task automatic t_unmapped();
    wr(12'hFFC, 32'hFFFF_FFFF, 4'hF);
    chk({30'h0, rs_v}, 32'h0);
    rd(12'hFFC);
    chk(rd_v, 32'h0);
    chk({30'h0, rs_v}, 32'h0);
    chk({17'h0, ext_awaddr[31:17]}, 32'h0000_7FFF);
  endtask
  task automatic t_reset();
    arst_n = 1'b0;
    @(negedge sys_clk);
    chk(ext_awaddr, {15'h0000, host_awaddr});
    arst_n = 1'b1;
    @(negedge sys_clk);
    chk(ext_araddr, {15'h0000, host_araddr});
    rd(12'h804);
    chk(rd_v, 32'h1720_0201);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Ceiling is far above the seventy or so cycles the scenarios need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (6) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    t_page();
    t_build();
    t_engines();
    t_unmapped();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
